// ### logic/lat_time_keeper.sv
`include "lat_cfg.svh"
module lat_time_keeper
  import lat_pkg::*;
#(
  parameter int         CYC_PER_US = `LAT_CYC_PER_US,
  parameter int         US_PER_SEC = `LAT_US_PER_SEC,
  parameter logic [1:0] LOSS_TICKS = 2'(`LAT_LOSS_TICKS)
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  input  wire logic        ppsIn,
  input  wire logic        nmeaStrobe,
  input  wire logic        nmeaIsGga,
  input  wire logic [31:0] nmeaSeconds,
  input  wire logic        ptpStrobe,
  input  wire logic        ptpServoLocked,
  input  wire logic [31:0] ptpSeconds,
  input  wire logic [19:0] ptpMicros,
  input  wire logic [15:0] azimuth,
  output      logic        tickOut,
  output      logic        posPacket,
  output      logic        fireTrigger,
  output      logic        pktReady,
  output      logic [31:0] pktDateTime,
  output      logic [31:0] pktStampSec,
  output      logic [19:0] pktStampUs,
  output      logic [31:0] nowSeconds,
  output      logic [19:0] nowMicros
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic lat_lock_type lockNext(input lat_lock_type cur, input logic seen,
                                            input logic miss);
    lockNext = cur;
    unique case (cur)
      LAT_LOCK_UNLOCKED: if (seen) lockNext = LAT_LOCK_LOCKED;
      LAT_LOCK_LOCKED: if (!seen && miss) lockNext = LAT_LOCK_LOST;
      LAT_LOCK_LOST: if (seen) lockNext = LAT_LOCK_LOCKED;
      default: lockNext = LAT_LOCK_UNLOCKED;
    endcase
  endfunction

  // missed-tick counter, saturating; a sighting in the same cycle wins
  function automatic logic [1:0] missNext(input logic [1:0] cur, input logic seen,
                                          input logic tick);
    if (seen) return 2'h0;
    if (tick && cur != 2'h3) return cur + 2'h1;
    return cur;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) old[8*i +: 8] = nw[8*i +: 8];
    end
    return old;
  endfunction

  // block end time relative to packet time, in ns
  function automatic logic [31:0] blockEndNs(input logic [2:0] blk, input logic dual);
    int back;
    if (blk == 3'h0 || blk > 3'(`LAT_BLOCKS)) return 32'h0;
    back = `LAT_BLOCKS - int'(blk);
    if (dual) back = back / 2;
    return 32'(-(`LAT_BLOCK_TAIL_NS + `LAT_BLOCK_STEP_NS * back));
  endfunction

  // firing step of a channel; two channels share each step
  function automatic logic [5:0] chanStep(input logic [6:0] ch);
    unique case (ch)
      7'h0c, 7'h28: return 6'h01;
      7'h12, 7'h26: return 6'h02;
      7'h0b, 7'h1a: return 6'h03;
      7'h11, 7'h20: return 6'h04;
      7'h08, 7'h17: return 6'h05;
      7'h0e, 7'h1d: return 6'h06;
      7'h14, 7'h23: return 6'h07;
      7'h0d, 7'h1c: return 6'h08;
      7'h13, 7'h22: return 6'h09;
      7'h0a, 7'h19: return 6'h0a;
      7'h10, 7'h1f: return 6'h0b;
      7'h16, 7'h25: return 6'h0c;
      7'h0f, 7'h1e: return 6'h0d;
      7'h15, 7'h24: return 6'h0e;
      7'h1b, 7'h2a: return 6'h0f;
      7'h18, 7'h21: return 6'h10;
      7'h01, 7'h2c: return 6'h11;
      7'h02, 7'h2e: return 6'h12;
      7'h03, 7'h34: return 6'h13;
      7'h04, 7'h32: return 6'h14;
      7'h05, 7'h30: return 6'h15;
      7'h06, 7'h36: return 6'h16;
      7'h29, 7'h3a: return 6'h17;
      7'h2f, 7'h3e: return 6'h18;
      7'h35, 7'h40: return 6'h19;
      7'h07, 7'h38: return 6'h1a;
      7'h2b, 7'h3b: return 6'h1b;
      7'h31, 7'h3f: return 6'h1c;
      7'h09, 7'h37: return 6'h1d;
      7'h27, 7'h39: return 6'h1e;
      7'h2d, 7'h3c: return 6'h1f;
      7'h33, 7'h3d: return 6'h20;
      default: return 6'h00; // no such channel
    endcase
  endfunction

  // channel offset in ns; table is linear in two segments
  function automatic logic [31:0] chanOfsNs(input logic [5:0] step);
    int s;
    s = int'(step);
    if (step == 6'h0) return 32'h0;
    if (s <= `LAT_FIRE_MID_STEP)
      return 32'(-`LAT_FIRE_FIRST_NS + `LAT_FIRE_STEP_A_NS * (s - 1));
    return 32'(-`LAT_FIRE_MID_NS + `LAT_FIRE_STEP_B_NS * (s - `LAT_FIRE_MID_STEP));
  endfunction

  // ----------------------------------------
  // registers and events
  // ----------------------------------------
  logic [3:0]   ctrlReg;
  logic [23:0]  trigIvlReg;
  logic [15:0]  queryReg;
  logic [7:0]   cycReg;
  logic [19:0]  usReg;
  logic [31:0]  secReg;
  logic         ppsPrevReg;
  logic [31:0]  nmeaSecReg;
  logic         nmeaFreshReg;
  lat_lock_type ppsStateReg;
  lat_lock_type nmeaStateReg;
  lat_net_type  ptpStateReg;
  logic [1:0]   ppsMissReg;
  logic [1:0]   nmeaMissReg;
  logic [1:0]   ptpMissReg;
  logic [23:0]  ivlCntReg;
  logic [15:0]  lastAzReg;
  logic [2:0]   blockCntReg;
  logic [31:0]  readData;
  logic         gnssMode;
  logic         usStep;
  logic         wrapTick;
  logic         ppsAlign;
  logic         ptpLoad;
  logic         nmeaAccept;
  logic         tickNow;
  logic         subSecSync;
  logic [23:0]  ivlEff;
  logic [16:0]  azDiff;
  logic         fireNow;
  logic [2:0]   returns;
  logic         pktFull;
  logic         wbReq;
  logic [31:0]  blockEndNow;
  logic [31:0]  fireOfsNow;

  assign gnssMode   = !ctrlReg[`LAT_CTRL_SRC_NET];
  assign usStep     = ce && cycReg == 8'(CYC_PER_US - 1);
  assign wrapTick   = usStep && usReg == 20'(US_PER_SEC - 1);
  assign ppsAlign   = ce && gnssMode && ppsIn && !ppsPrevReg;
  assign ptpLoad    = ce && !gnssMode && ptpStrobe;
  assign nmeaAccept = ce && gnssMode && nmeaStrobe
                      && nmeaIsGga == ctrlReg[`LAT_CTRL_GGA];
  // a pulse near the end of the second ticks early; one just after a wrap only realigns
  assign tickNow    = ppsAlign ? usReg >= 20'(US_PER_SEC / 2) : wrapTick;
  assign subSecSync = gnssMode ? ppsStateReg == LAT_LOCK_LOCKED
                      : ptpStateReg inside {LAT_NET_TRACK, LAT_NET_LOCKED};
  assign ivlEff     = (trigIvlReg == 24'h0) ? 24'h1 : trigIvlReg;
  assign azDiff     = (azimuth >= lastAzReg) ? {1'b0, azimuth - lastAzReg}
                      : 17'({1'b0, azimuth} + `LAT_AZ_FULL - {1'b0, lastAzReg});
  assign fireNow    = ctrlReg[`LAT_CTRL_AZ_TRIG] ? ce && azDiff >= 17'(ivlEff)
                      : usStep && ivlCntReg >= ivlEff - 24'h1;
  assign returns    = ctrlReg[`LAT_CTRL_DUAL] ? 3'h2 : 3'h1;
  assign pktFull    = blockCntReg + returns >= 3'(`LAT_BLOCKS);
  assign wbReq      = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign blockEndNow = blockEndNs(queryReg[2:0], ctrlReg[`LAT_CTRL_DUAL]);
  assign fireOfsNow  = blockEndNow + chanOfsNs(chanStep(queryReg[14:8]));

  // ----------------------------------------
  // local time base
  // ----------------------------------------
  // prescaler and microsecond counter run free unless a reference realigns them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cycReg <= 8'h0;
      usReg  <= 20'h0;
    end else if (ce) begin
      if (ppsAlign || ptpLoad) begin
        cycReg <= 8'h0;
        usReg  <= ptpLoad ? ptpMicros : 20'h0;
      end else if (usStep) begin
        cycReg <= 8'h0;
        usReg  <= wrapTick ? 20'h0 : usReg + 20'h1;
      end else begin
        cycReg <= cycReg + 8'h1;
      end
    end
  end

  // seconds: master time, sentence plus one, or plain counting on drift
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      secReg <= `LAT_EPOCH_SEC;
    end else if (ptpLoad) begin
      secReg <= ptpSeconds;
    end else if (tickNow) begin
      if (gnssMode && nmeaFreshReg) secReg <= nmeaSecReg + 32'h1;
      else secReg <= secReg + 32'h1;
    end
  end

  // latest accepted sentence; a sentence in the tick cycle survives for the next tick
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nmeaSecReg   <= `LAT_EPOCH_SEC;
      nmeaFreshReg <= 1'b0;
      ppsPrevReg   <= 1'b0;
    end else if (ce) begin
      ppsPrevReg <= ppsIn;
      if (nmeaAccept) begin
        nmeaSecReg   <= nmeaSeconds;
        nmeaFreshReg <= 1'b1;
      end else if (tickNow) begin
        nmeaFreshReg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // lock tracking
  // ----------------------------------------
  // a source is lost after LOSS_TICKS internal ticks without a sighting
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ppsStateReg  <= LAT_LOCK_UNLOCKED;
      nmeaStateReg <= LAT_LOCK_UNLOCKED;
      ppsMissReg   <= 2'h0;
      nmeaMissReg  <= 2'h0;
    end else if (ce) begin
      ppsMissReg   <= missNext(ppsMissReg, ppsAlign, tickNow);
      nmeaMissReg  <= missNext(nmeaMissReg, nmeaAccept, tickNow);
      ppsStateReg  <= lockNext(ppsStateReg, ppsAlign, ppsMissReg >= LOSS_TICKS);
      nmeaStateReg <= lockNext(nmeaStateReg, nmeaAccept, nmeaMissReg >= LOSS_TICKS);
    end
  end

  // network source state; a message moves it only while ctrlReg selects the network source
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ptpStateReg <= LAT_NET_FREE;
      ptpMissReg  <= 2'h0;
    end else if (ce) begin
      ptpMissReg <= missNext(ptpMissReg, ptpLoad, tickNow);
      unique case (ptpStateReg)
        LAT_NET_FREE, LAT_NET_FROZEN: begin
          if (ptpLoad) ptpStateReg <= ptpServoLocked ? LAT_NET_LOCKED : LAT_NET_TRACK;
        end
        LAT_NET_TRACK, LAT_NET_LOCKED: begin
          if (ptpLoad) ptpStateReg <= ptpServoLocked ? LAT_NET_LOCKED : LAT_NET_TRACK;
          else if (ptpMissReg >= LOSS_TICKS) ptpStateReg <= LAT_NET_FROZEN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // firing rounds and packet time
  // ----------------------------------------
  // interval counter restarts on each trigger; azimuth mode remembers the last angle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ivlCntReg <= 24'h0;
      lastAzReg <= 16'h0;
    end else if (ce) begin
      if (fireNow) begin
        ivlCntReg <= 24'h0;
        lastAzReg <= azimuth;
      end else if (usStep) begin
        ivlCntReg <= ivlCntReg + 24'h1;
      end
    end
  end

  // the round that fills the last block fixes the packet time
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      blockCntReg <= 3'h0;
      pktDateTime <= `LAT_EPOCH_SEC;
      pktStampSec <= `LAT_EPOCH_SEC;
      pktStampUs  <= 20'h0;
      pktReady    <= 1'b0;
      fireTrigger <= 1'b0;
    end else if (ce) begin
      fireTrigger <= fireNow;
      pktReady    <= fireNow && pktFull;
      if (fireNow) begin
        blockCntReg <= pktFull ? 3'h0 : blockCntReg + returns;
        if (pktFull) begin
          pktDateTime <= secReg;
          pktStampSec <= secReg;
          pktStampUs  <= usReg;
        end
      end
    end
  end

  // tick, position packet and current time outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tickOut    <= 1'b0;
      posPacket  <= 1'b0;
      nowSeconds <= `LAT_EPOCH_SEC;
      nowMicros  <= 20'h0;
    end else if (ce) begin
      tickOut    <= tickNow;
      posPacket  <= tickNow && gnssMode;
      nowSeconds <= secReg;
      nowMicros  <= usReg;
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  always_comb begin
    unique case (wb_adr_i & 8'hfc)
      `LAT_OFS_CTRL:     readData = {28'h0, ctrlReg};
      `LAT_OFS_TRIG_IVL: readData = {8'h0, trigIvlReg};
      `LAT_OFS_STATUS:   readData = {25'h0, subSecSync, ptpStateReg, nmeaStateReg,
                                     ppsStateReg};
      `LAT_OFS_NOW_SEC:  readData = secReg;
      `LAT_OFS_NOW_US:   readData = {12'h0, usReg};
      `LAT_OFS_PKT_DT:   readData = pktDateTime;
      `LAT_OFS_PKT_US:   readData = {12'h0, pktStampUs};
      `LAT_OFS_QUERY:    readData = {16'h0, queryReg};
      `LAT_OFS_BLK_END:  readData = blockEndNow;
      `LAT_OFS_FIRE_OFS: readData = fireOfsNow;
      default:           readData = 32'h0; // unmapped reads zero
    endcase
  end

  // one wait state: ack comes the cycle after the request, then drops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce) begin
      wb_ack_o <= wbReq;
      if (wbReq) wb_dat_o <= wb_we_i ? 32'h0 : readData;
    end
  end

  // writable settings; reserved bits are dropped
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrlReg    <= `LAT_CTRL_RST;
      trigIvlReg <= `LAT_TRIG_IVL_RST;
      queryReg   <= `LAT_QUERY_RST;
    end else if (wbReq && wb_we_i) begin
      if ((wb_adr_i & 8'hfc) == `LAT_OFS_CTRL)
        ctrlReg <= 4'(laneMerge({28'h0, ctrlReg}, wb_dat_i, wb_sel_i));
      if ((wb_adr_i & 8'hfc) == `LAT_OFS_TRIG_IVL)
        trigIvlReg <= 24'(laneMerge({8'h0, trigIvlReg}, wb_dat_i, wb_sel_i));
      if ((wb_adr_i & 8'hfc) == `LAT_OFS_QUERY)
        queryReg <= 16'(laneMerge({16'h0, queryReg}, wb_dat_i, wb_sel_i));
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  pos_packet_a: assert property (tickNow && gnssMode |=> posPacket && tickOut)
    else $error("position packet missing after tick");
  net_no_packet_a: assert property (!gnssMode && $past(!gnssMode) |-> !posPacket)
    else $error("position packet in network mode");
  nmea_load_a: assert property (tickNow && gnssMode && nmeaFreshReg |=>
    secReg == $past(nmeaSecReg) + 32'h1)
    else $error("sentence time not loaded plus one");
  free_count_a: assert property (tickNow && !ptpLoad && !(gnssMode && nmeaFreshReg) |=>
    secReg == $past(secReg) + 32'h1)
    else $error("seconds not counted on tick");
  pps_align_a: assert property (ppsAlign |=> usReg == 20'h0 && cycReg == 8'h0)
    else $error("tick not aligned to pulse");
  pps_lost_a: assert property (ppsStateReg == LAT_LOCK_LOCKED && ppsMissReg >= LOSS_TICKS
    && !ppsAlign && ce |=> ppsStateReg == LAT_LOCK_LOST
    ##1 (!subSecSync || $past(ppsAlign) || !gnssMode))
    else $error("lost pulse not reported");
  ptp_load_a: assert property (ptpLoad |=> secReg == $past(ptpSeconds)
    && usReg == $past(ptpMicros))
    else $error("master time not taken");
  pkt_time_a: assert property (fireNow && pktFull |=> pktReady && fireTrigger
    && pktStampSec == $past(secReg) && pktStampUs == $past(usReg))
    else $error("packet time not trigger time");
  pkt_fields_a: assert property (pktReady |-> pktDateTime == pktStampSec)
    else $error("date and stamp fields differ");
  block_fill_a: assert property (fireNow && !pktFull |=>
    blockCntReg == $past(blockCntReg) + $past(returns))
    else $error("block count wrong");
  dual_pair_a: assert property (ctrlReg[`LAT_CTRL_DUAL] && queryReg[2:0] == 3'h5 |->
    blockEndNow == 32'(-`LAT_BLOCK_TAIL_NS))
    else $error("dual pair end time wrong");
  first_fire_a: assert property (!ctrlReg[`LAT_CTRL_DUAL] && queryReg == 16'h2806 |->
    fireOfsNow == 32'(-`LAT_BLOCK_TAIL_NS - `LAT_FIRE_FIRST_NS))
    else $error("first step offset wrong");
  time_trig_a: assert property (!ctrlReg[`LAT_CTRL_AZ_TRIG] && fireNow |->
    usStep && ivlCntReg + 24'h1 >= ivlEff)
    else $error("time trigger off interval");

  pps_lock_c:  cover property (ppsStateReg == LAT_LOCK_LOCKED && ppsAlign);
  nmea_load_c: cover property (tickNow && gnssMode && nmeaFreshReg);
  ptp_lock_c:  cover property (ptpStateReg == LAT_NET_LOCKED ##1 ptpLoad);
  pkt_dual_c:  cover property (pktReady && ctrlReg[`LAT_CTRL_DUAL]);

endmodule // lat_time_keeper

// ### inc/lat_cfg.svh
`ifndef LAT_CFG_SVH
`define LAT_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define LAT_CLK_HZ         25000000
`define LAT_US_PER_SEC     1000000
`define LAT_CYC_PER_US     (`LAT_CLK_HZ / `LAT_US_PER_SEC)
`define LAT_LOSS_TICKS     2
`define LAT_EPOCH_SEC      32'h0000_0000
`define LAT_BLOCKS         6
`define LAT_AZ_FULL        17'h08ca0
`define LAT_BLOCK_TAIL_NS  42580
`define LAT_BLOCK_STEP_NS  55560
`define LAT_FIRE_FIRST_NS  54668
`define LAT_FIRE_MID_NS    23180
`define LAT_FIRE_STEP_A_NS 1968
`define LAT_FIRE_STEP_B_NS 1304
`define LAT_FIRE_MID_STEP  17
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LAT_OFS_CTRL      8'h00
`define LAT_OFS_TRIG_IVL  8'h04
`define LAT_OFS_STATUS    8'h08
`define LAT_OFS_NOW_SEC   8'h0c
`define LAT_OFS_NOW_US    8'h10
`define LAT_OFS_PKT_DT    8'h14
`define LAT_OFS_PKT_US    8'h18
`define LAT_OFS_QUERY     8'h1c
`define LAT_OFS_BLK_END   8'h20
`define LAT_OFS_FIRE_OFS  8'h24
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define LAT_CTRL_SRC_NET  0
`define LAT_CTRL_GGA      1
`define LAT_CTRL_AZ_TRIG  2
`define LAT_CTRL_DUAL     3
`define LAT_CTRL_RST      4'h0
`define LAT_TRIG_IVL_RST  24'h000038
`define LAT_QUERY_RST     16'h0106
`endif

// ### inc/lat_pkg.sv
package lat_pkg;
  // lock state of the pulse and sentence inputs
  typedef enum logic [1:0] {
    LAT_LOCK_UNLOCKED = 2'b00,
    LAT_LOCK_LOCKED   = 2'b01,
    LAT_LOCK_LOST     = 2'b10
  } lat_lock_type;
  // state of the network time source
  typedef enum logic [1:0] {
    LAT_NET_FREE   = 2'b00,
    LAT_NET_TRACK  = 2'b01,
    LAT_NET_LOCKED = 2'b10,
    LAT_NET_FROZEN = 2'b11
  } lat_net_type;
endpackage

// ### tb/lat_rx_model.sv
module lat_rx_model
  import lat_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        ppsOn,
  input  wire logic        ptpOn,
  input  wire logic        isGga,
  input  wire logic [31:0] baseSec,
  output      logic        ppsIn,
  output      logic        nmeaStrobe,
  output      logic        nmeaIsGga,
  output      logic [31:0] nmeaSeconds,
  output      logic        ptpStrobe,
  output      logic        ptpServoLocked,
  output      logic [31:0] ptpSeconds,
  output      logic [19:0] ptpMicros
);
  timeunit 1ns;
  timeprecision 1ps;
  // receiver second is a bit short of ours, so each pulse lands before the free wrap
  localparam int PERIOD = 1990;
  int          cycCnt_reg = 0;
  logic [31:0] sec_reg    = 32'h0;
  logic        nmeaHit;
  logic        ptpHit;
  assign nmeaHit = ppsOn && cycCnt_reg == 300;
  assign ptpHit = ptpOn && (cycCnt_reg == 100 || cycCnt_reg == 1100);
  assign nmeaIsGga = isGga;
  assign ptpServoLocked = ptpOn;
  initial begin
    ppsIn = 1'b0;
    nmeaStrobe = 1'b0;
    nmeaSeconds = 32'h0;
    ptpStrobe = 1'b0;
    ptpSeconds = 32'h0;
    ptpMicros = 20'h0;
  end
  // pulse first, sentence later; values are scrambled between strobes so nothing stale helps
  always @(posedge clk_sys) begin
    cycCnt_reg <= (cycCnt_reg == PERIOD - 1) ? 0 : cycCnt_reg + 1;
    ppsIn <= ppsOn && cycCnt_reg < 200;
    nmeaStrobe <= nmeaHit;
    nmeaSeconds <= nmeaHit ? baseSec + sec_reg : ~nmeaSeconds;
    ptpStrobe <= ptpHit;
    ptpSeconds <= ptpHit ? baseSec + sec_reg : ~ptpSeconds;
    ptpMicros <= ptpHit ? 20'(cycCnt_reg / 2) : ~ptpMicros;
    if (cycCnt_reg == 300 || cycCnt_reg == 1100) begin
      sec_reg <= sec_reg + 32'h1;
    end
  end
endmodule // lat_rx_model

// ### tb/testbench.sv
module testbench
  import lat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 2;
  logic clk_sys = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic        ce = 1'b1;
  logic [31:0] wbDatI = 32'h0, wbDatO, baseSec = 32'h0, lastNmea, lastPtpS, nowSeconds;
  logic [31:0] pktDateTime, pktStampSec, nmeaSeconds, ptpSeconds, fireCnt = 0, posCnt = 0;
  logic [19:0] ptpMicros, pktStampUs, nowMicros, lastPtpU;
  logic [15:0] azimuth = 16'h0;
  logic [1:0]  ppsHist = 2'b00;
  logic ppsOn = 1'b0, ptpOn = 1'b0, isGga = 1'b0, ppsIn, nmeaStrobe, nmeaIsGga, ptpStrobe;
  logic ptpServoLocked, tickOut, posPacket, fireTrigger, pktReady;
  int err_count = 0, comparisons = 0;
  always #20 clk_sys = ~clk_sys;
  lat_time_keeper #(.CYC_PER_US(CYC), .US_PER_SEC(1000)) i_lat_time_keeper (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .ppsIn(ppsIn), .nmeaStrobe(nmeaStrobe), .nmeaIsGga(nmeaIsGga),
    .nmeaSeconds(nmeaSeconds), .ptpStrobe(ptpStrobe), .ptpServoLocked(ptpServoLocked),
    .ptpSeconds(ptpSeconds), .ptpMicros(ptpMicros), .azimuth(azimuth), .tickOut(tickOut),
    .posPacket(posPacket), .fireTrigger(fireTrigger), .pktReady(pktReady),
    .pktDateTime(pktDateTime), .pktStampSec(pktStampSec), .pktStampUs(pktStampUs),
    .nowSeconds(nowSeconds), .nowMicros(nowMicros));
  lat_rx_model i_lat_rx_model (
    .clk_sys(clk_sys), .ppsOn(ppsOn), .ptpOn(ptpOn), .isGga(isGga), .baseSec(baseSec),
    .ppsIn(ppsIn), .nmeaStrobe(nmeaStrobe), .nmeaIsGga(nmeaIsGga), .nmeaSeconds(nmeaSeconds),
    .ptpStrobe(ptpStrobe), .ptpServoLocked(ptpServoLocked), .ptpSeconds(ptpSeconds),
    .ptpMicros(ptpMicros));
  // monitors sample mid-cycle, where every registered output has settled
  always @(negedge clk_sys) begin
    ppsHist <= {ppsHist[0], ppsIn};
    if (nmeaStrobe === 1'b1) lastNmea <= nmeaSeconds;
    if (ptpStrobe === 1'b1) lastPtpS <= ptpSeconds;
    if (ptpStrobe === 1'b1) lastPtpU <= ptpMicros;
    fireCnt <= fireCnt + 32'(fireTrigger === 1'b1);
    posCnt <= posCnt + 32'(posPacket === 1'b1);
  end
  // ---------------------------------------------------------------
  // expectations and bus cycles
  // ---------------------------------------------------------------
  function automatic logic [31:0] blkEnd(input int d, input int b);
    return -(42580 + 55560 * (d != 0 ? (6 - b) / 2 : 6 - b));
  endfunction
  function automatic logic [31:0] chOfs(input int s);
    return s <= 17 ? -(54668 - 1968 * (s - 1)) : -(23180 - 1304 * (s - 17));
  endfunction
  task automatic give_verdict;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until ack is seen; a hung slave ends the run
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, a, 4'hf, d};
    // ack and read data are taken at the rising edge that samples ack high
    do begin @(posedge clk_sys); n++; end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    if (n >= 50) begin err_count++; give_verdict(); end
    {wbCyc, wbStb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // 0 tick, 1 fire, 2 master strobe, 3 packet ready
  task automatic waitFor(input int w, input int lim, output int n);
    n = 0;
    do begin @(negedge clk_sys); n++; end
    while (!(w == 0 ? tickOut === 1'b1 : w == 1 ? fireTrigger === 1'b1 :
             w == 2 ? ptpStrobe === 1'b1 : pktReady === 1'b1) && n < lim);
    if (n >= lim) begin err_count++; give_verdict(); end
  endtask
  task automatic tickStep;
    int n;
    logic [31:0] s0;
    waitFor(0, 2100, n);
    s0 = nowSeconds;
    @(negedge clk_sys);
    chk(nowSeconds, s0 + 32'h1);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n, k, d, b, ivl;
    logic [31:0] c0;
    static int chs[8] = '{12, 40, 18, 1, 44, 9, 51, 61};
    static int stp[8] = '{1, 1, 2, 17, 17, 29, 32, 32};
    void'($urandom(32'h055861a5));
    isGga <= 1'($urandom);
    baseSec <= $urandom;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rdChk(8'h00, 32'h0, '1);
    rdChk(8'h04, 32'h38, '1);
    rdChk(8'h1c, 32'h106, '1);
    rdChk(8'h08, 32'h0, '1);
    wr(8'h40, 32'hffffffff);
    rdChk(8'h40, 32'h0, '1);
    // clock enable low must freeze the time base
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys);
    c0 = 32'(nowMicros);
    repeat (20) @(posedge clk_sys);
    chk(32'(nowMicros), c0);
    ce <= 1'b1;
    waitFor(0, 2100, n);
    chk(32'(posPacket), 32'h1);
    @(negedge clk_sys);
    chk(nowSeconds, 32'h1);
    rdChk(8'h08, 32'h0, 32'h40);
    wr(8'h00, {30'h0, isGga, 1'b0});
    ppsOn <= 1'b1;
    for (k = 0; k < 5; k++) begin
      waitFor(0, 2100, n);
      if (k >= 2) chk({29'h0, ppsHist, ppsIn}, 32'h3);
      if (k >= 2) chk(32'(posPacket), 32'h1);
      @(negedge clk_sys);
      if (k >= 2) chk(nowSeconds, lastNmea + 32'h1);
    end
    rdChk(8'h08, 32'h45, '1);
    ppsOn <= 1'b0;
    for (k = 0; k < 3; k++) tickStep();
    rdChk(8'h08, 32'h0a, 32'h0f);
    for (d = 0; d < 2; d++) begin
      wr(8'h00, 32'(d) << 3);
      for (b = 1; b <= 6; b++) begin
        wr(8'h1c, 32'(b));
        rdChk(8'h20, blkEnd(d, b), '1);
      end
    end
    wr(8'h00, 32'h0);
    for (k = 0; k < 8; k++) begin
      b = $urandom_range(6, 1);
      wr(8'h1c, (32'(chs[k]) << 8) | 32'(b));
      rdChk(8'h24, blkEnd(0, b) + chOfs(stp[k]), '1);
    end
    ivl = $urandom_range(20, 5);
    wr(8'h04, 32'(ivl));
    for (d = 0; d < 2; d++) begin
      wr(8'h00, 32'(d) << 3);
      waitFor(3, 300, n);
      c0 = 0;
      for (k = 0; k < 12; k++) begin
        waitFor(1, 300, n);
        chk(32'(n), 32'(ivl * CYC));
        if (pktReady === 1'b1) c0++;
        if (pktReady === 1'b1) chk(pktStampSec, pktDateTime);
        if (pktReady === 1'b1) chk(pktDateTime, nowSeconds);
        if (pktReady === 1'b1) chk(32'(pktStampUs), 32'(nowMicros));
      end
      chk(c0, d != 0 ? 32'h4 : 32'h2);
    end
    wr(8'h04, 32'h38);
    wr(8'h00, 32'h4);
    azimuth <= 16'($urandom_range(30000, 0));
    repeat (4) @(posedge clk_sys);
    c0 = fireCnt;
    repeat (200) @(posedge clk_sys);
    chk(fireCnt - c0, 32'h0);
    for (k = 0; k < 120; k++) begin
      @(posedge clk_sys);
      azimuth <= azimuth + 16'h000a;
    end
    repeat (4) @(posedge clk_sys);
    chk(32'((fireCnt - c0) inside {[20:22]}), 32'h1);
    wr(8'h00, 32'h1);
    tickStep();
    ptpOn <= 1'b1;
    for (k = 0; k < 3; k++) begin
      waitFor(2, 1200, n);
      repeat (2) @(negedge clk_sys);
      chk(nowSeconds, lastPtpS);
      chk(32'(20'(nowMicros - lastPtpU) <= 20'h1), 32'h1);
    end
    rdChk(8'h08, 32'h20, 32'h30);
    c0 = posCnt;
    repeat (2100) @(posedge clk_sys);
    chk(posCnt - c0, 32'h0);
    ptpOn <= 1'b0;
    for (k = 0; k < 3; k++) tickStep();
    rdChk(8'h08, 32'h30, 32'h30);
    give_verdict();
  end
endmodule // testbench
